// [hw/lcdc_pkg.sv]
// Purpose: Constants shared by the LCD command decoder, its checker, the host model and the bench.
// Assumes: Byte-wide host transfers, one clock domain.
// Notes:   Command codes are compared after masking with their pattern masks, except read-modify-write, end and reset, which must match whole.
package lcdc_pkg;

  // ------------------------------------------------------------------
  // Widths and geometry
  // ------------------------------------------------------------------
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned COL_W      = 7;
  localparam int unsigned LINE_W     = 6;
  localparam int unsigned VOL_W      = 5;
  localparam int unsigned RATIO_W    = 3;
  localparam int unsigned PWR_W      = 3;
  localparam int unsigned NUM_PAGES  = 9;
  localparam int unsigned NUM_COLS   = 102;
  localparam int unsigned RAM_DEPTH  = NUM_PAGES * NUM_COLS;
  localparam int unsigned RAM_AW     = 10;

  localparam logic [COL_W-1:0]  COL_LAST  = 7'h65;
  localparam logic [PAGE_W-1:0] PAGE_LAST = 4'h7;
  localparam logic [COL_W-1:0]  COL_ONE   = 7'h01;
  localparam logic [PAGE_W-1:0] PAGE_ONE  = 4'h1;

  // ------------------------------------------------------------------
  // Command codes and masks
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_DISP_ONOFF = 8'hae;
  localparam logic [7:0] CMD_REVERSE    = 8'ha6;
  localparam logic [7:0] CMD_ALL_ON     = 8'ha4;
  localparam logic [7:0] CMD_SEG_DIR    = 8'ha0;
  localparam logic [7:0] CMD_BIAS       = 8'ha2;
  localparam logic [7:0] MASK_BIT0      = 8'hfe;
  localparam logic [7:0] CMD_PAGE       = 8'hb0;
  localparam logic [7:0] CMD_COL_HI     = 8'h10;
  localparam logic [7:0] CMD_COL_LO     = 8'h00;
  localparam logic [7:0] CMD_COM_DIR    = 8'hc0;
  localparam logic [7:0] CMD_TEST       = 8'hd0;
  localparam logic [7:0] MASK_NIBBLE    = 8'hf0;
  localparam logic [7:0] MASK_TEST      = 8'hd0;
  localparam logic [7:0] CMD_START_LINE = 8'h40;
  localparam logic [7:0] MASK_TOP2      = 8'hc0;
  localparam logic [7:0] CMD_PWR_CTRL   = 8'h28;
  localparam logic [7:0] CMD_RATIO      = 8'h20;
  localparam logic [7:0] MASK_TOP5      = 8'hf8;
  localparam logic [7:0] CMD_VOLUME     = 8'h80;
  localparam logic [7:0] MASK_TOP3      = 8'he0;
  localparam logic [7:0] CMD_RMW        = 8'he0;
  localparam logic [7:0] CMD_END        = 8'hee;
  localparam logic [7:0] CMD_RESET      = 8'he2;
  localparam logic [7:0] CMD_NOP        = 8'he3;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned BIT_BOOST   = 2;
  localparam int unsigned BIT_REG     = 1;
  localparam int unsigned BIT_FOLLOW  = 0;
  localparam int unsigned BIT_COM_DIR = 3;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [PWR_W-1:0]   RST_PWR    = 3'h0;
  localparam logic [RATIO_W-1:0] RST_RATIO  = 3'h0;
  localparam logic [VOL_W-1:0]   RST_VOLUME = 5'h10;
  localparam logic               RST_BIAS6  = 1'b1;
  localparam logic               RST_DISP   = 1'b0;
  localparam logic               RST_ALL_ON = 1'b1;
  localparam logic [PAGE_W-1:0]  RST_PAGE   = 4'h0;
  localparam logic [COL_W-1:0]   RST_COL    = 7'h00;
  localparam logic [LINE_W-1:0]  RST_LINE   = 6'h00;

  localparam logic [2:0] SERIAL_LAST = 3'h7;

  typedef enum logic [1:0] {
    LCDC_ST_IDLE,
    LCDC_ST_READ,
    LCDC_ST_ANSWER
  } lcdc_state_t;

endpackage : lcdc_pkg

// [hw/lcdc_fifo.sv]
// Purpose: Small synchronous FIFO holding host bytes ahead of the decoder.
// Assumes: One clock; valid/ready handshake on both sides.
// Notes:   Full and empty are exact; depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module lcdc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                     (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : lcdc_fifo
`default_nettype wire

// [hw/lcdc_decoder.sv]
// Purpose: Command decoder and display memory for a dot-matrix LCD driver.
// Assumes: Host strobes are single-cycle pulses synchronous to sys_clk.
// Notes:   Writes and commands queue in a 4-deep FIFO; reads wait for it to drain.
`timescale 1ns/1ps
`default_nettype none
module lcdc_decoder
  import lcdc_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Parallel host port
  input  wire logic               cmd_data_select,
  input  wire logic               write_strobe,
  input  wire logic               read_strobe,
  input  wire logic [BYTE_W-1:0]  host_wdata,
  output logic      [BYTE_W-1:0]  host_rdata,
  output logic                    host_rvalid,
  output logic                    host_wready,
  // Serial host port
  input  wire logic               serial_select,
  input  wire logic               serial_clk_en,
  input  wire logic               serial_bit,
  // Settings
  output logic      [PWR_W-1:0]   power_ctrl,
  output logic      [RATIO_W-1:0] regulator_divider_ratio,
  output logic      [VOL_W-1:0]   volume_field,
  output logic                    bias_sixth,
  output logic                    display_on,
  output logic                    display_reverse,
  output logic                    all_points_on,
  output logic                    segment_reverse,
  output logic                    common_reverse,
  output logic      [LINE_W-1:0]  start_line,
  output logic      [PAGE_W-1:0]  page_addr,
  output logic      [COL_W-1:0]   column_addr,
  output logic                    rmw_active,
  output logic                    test_mode,
  // Power saver effects
  output logic                    power_saver,
  output logic                    osc_enable,
  output logic                    supply_enable,
  output logic                    drivers_grounded,
  output logic                    pixels_forced_on
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] code,
                                  input logic [7:0] mask);
    return (b & mask) == code;
  endfunction

  function automatic logic [RAM_AW-1:0] ram_index(input logic [PAGE_W-1:0] p,
                                                   input logic [COL_W-1:0] c);
    return RAM_AW'(p * NUM_COLS + c);
  endfunction

  // ----------------------------------------------------------------
  // Host byte capture (parallel or serial) into the FIFO
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] shift_reg;
  logic [2:0]        bit_cnt_reg;
  logic              ser_done;
  logic              fifo_in_valid;
  logic [BYTE_W:0]   fifo_in_data;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [BYTE_W:0]   fifo_out_data;

  assign ser_done      = serial_select && serial_clk_en && (bit_cnt_reg == SERIAL_LAST);
  assign fifo_in_valid = serial_select ? ser_done : write_strobe;
  assign fifo_in_data  = serial_select ? {cmd_data_select, shift_reg[BYTE_W-2:0], serial_bit}
                                       : {cmd_data_select, host_wdata};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (serial_select && serial_clk_en) begin
      shift_reg   <= {shift_reg[BYTE_W-2:0], serial_bit};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  lcdc_fifo #(.WIDTH(BYTE_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Read sequencing: a read waits until queued writes have landed
  // ----------------------------------------------------------------
  lcdc_state_t state_reg;
  logic        rd_go;
  logic        is_data;
  logic [7:0]  b;
  logic        exec;

  assign rd_go          = (state_reg == LCDC_ST_READ) && !fifo_out_valid;
  assign fifo_out_ready = (state_reg != LCDC_ST_ANSWER);
  assign exec           = fifo_out_valid && fifo_out_ready;
  assign is_data        = fifo_out_data[BYTE_W];
  assign b              = fifo_out_data[BYTE_W-1:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LCDC_ST_IDLE;
    end else begin
      unique case (state_reg)
        LCDC_ST_IDLE: begin
          if (read_strobe && cmd_data_select && !serial_select) begin
            state_reg <= LCDC_ST_READ;
          end
        end
        LCDC_ST_READ: begin
          if (!fifo_out_valid) begin
            state_reg <= LCDC_ST_ANSWER;
          end
        end
        LCDC_ST_ANSWER: begin
          state_reg <= LCDC_ST_IDLE;
        end
        default: begin
          state_reg <= LCDC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Display memory (not touched by any reset)
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] ram [RAM_DEPTH];
  logic [BYTE_W-1:0] latch_reg;
  logic [BYTE_W-1:0] rdata_reg;
  logic              rvalid_reg;

  always_ff @(posedge sys_clk) begin
    if (exec && is_data) begin
      ram[ram_index(page_addr, column_addr)] <= b;
    end
  end

  // Read answers the byte latched by the previous read: the dummy read
  // after an address set falls out of this pipeline.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg  <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_go;
      if (rd_go) begin
        rdata_reg <= latch_reg;
        latch_reg <= ram[ram_index(page_addr, column_addr)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  logic             soft_rst;
  logic [COL_W-1:0] saved_col_reg;
  logic             col_wrap;

  assign soft_rst = exec && !is_data && (b == CMD_RESET);
  assign col_wrap = (column_addr == COL_LAST);

  // Operating settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ctrl              <= RST_PWR;
      regulator_divider_ratio <= RST_RATIO;
      volume_field            <= RST_VOLUME;
      bias_sixth              <= RST_BIAS6;
      display_on              <= RST_DISP;
      all_points_on           <= RST_ALL_ON;
      display_reverse         <= 1'b0;
      segment_reverse         <= 1'b0;
      common_reverse          <= 1'b0;
      start_line              <= RST_LINE;
      test_mode               <= 1'b0;
    end else if (soft_rst) begin
      power_ctrl              <= RST_PWR;
      regulator_divider_ratio <= RST_RATIO;
      volume_field            <= RST_VOLUME;
      bias_sixth              <= RST_BIAS6;
      display_on              <= RST_DISP;
      all_points_on           <= RST_ALL_ON;
      display_reverse         <= 1'b0;
      segment_reverse         <= 1'b0;
      common_reverse          <= 1'b0;
      start_line              <= RST_LINE;
      test_mode               <= 1'b0;
    end else if (exec && !is_data) begin
      if (cmd_is(b, CMD_DISP_ONOFF, MASK_BIT0)) begin
        display_on <= b[0];
        test_mode  <= 1'b0;
      end else if (cmd_is(b, CMD_REVERSE, MASK_BIT0)) begin
        display_reverse <= b[0];
      end else if (cmd_is(b, CMD_ALL_ON, MASK_BIT0)) begin
        all_points_on <= b[0];
      end else if (cmd_is(b, CMD_SEG_DIR, MASK_BIT0)) begin
        segment_reverse <= b[0];
      end else if (cmd_is(b, CMD_BIAS, MASK_BIT0)) begin
        bias_sixth <= b[0];
      end else if (cmd_is(b, CMD_COM_DIR, MASK_NIBBLE)) begin
        common_reverse <= b[BIT_COM_DIR];
      end else if (cmd_is(b, CMD_START_LINE, MASK_TOP2)) begin
        start_line <= b[LINE_W-1:0];
      end else if (cmd_is(b, CMD_PWR_CTRL, MASK_TOP5)) begin
        power_ctrl <= b[PWR_W-1:0];
      end else if (cmd_is(b, CMD_RATIO, MASK_TOP5)) begin
        regulator_divider_ratio <= b[RATIO_W-1:0];
      end else if (cmd_is(b, CMD_VOLUME, MASK_TOP3)) begin
        volume_field <= b[VOL_W-1:0];
      end else if (cmd_is(b, CMD_TEST, MASK_TEST)) begin
        test_mode <= 1'b1;
      end
      // Anything else leaves settings alone
    end
  end

  // Addresses and read-modify-write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_addr     <= RST_PAGE;
      column_addr   <= RST_COL;
      rmw_active    <= 1'b0;
      saved_col_reg <= RST_COL;
    end else if (soft_rst) begin
      page_addr   <= RST_PAGE;
      column_addr <= RST_COL;
      rmw_active  <= 1'b0;
    end else if (exec && is_data) begin
      // Writes always advance, wrapping into the next page
      column_addr <= col_wrap ? RST_COL : column_addr + COL_ONE;
      if (col_wrap) begin
        page_addr <= (page_addr == PAGE_LAST) ? RST_PAGE : page_addr + PAGE_ONE;
      end
    end else if (exec) begin
      if (cmd_is(b, CMD_PAGE, MASK_NIBBLE)) begin
        page_addr <= b[PAGE_W-1:0];
      end else if (cmd_is(b, CMD_COL_HI, MASK_NIBBLE)) begin
        column_addr <= {b[2:0], column_addr[3:0]};
      end else if (cmd_is(b, CMD_COL_LO, MASK_NIBBLE)) begin
        column_addr <= {column_addr[COL_W-1:4], b[3:0]};
      end else if (b == CMD_RMW) begin
        rmw_active    <= 1'b1;
        saved_col_reg <= column_addr;
      end else if (b == CMD_END) begin
        rmw_active  <= 1'b0;
        column_addr <= saved_col_reg;
      end
    end else if (rd_go && !rmw_active) begin
      // Reads advance only outside read-modify-write
      column_addr <= col_wrap ? RST_COL : column_addr + COL_ONE;
      if (col_wrap) begin
        page_addr <= (page_addr == PAGE_LAST) ? RST_PAGE : page_addr + PAGE_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power saver and its effects
  // ----------------------------------------------------------------
  logic saver_next;

  // Either order of all-on and display-off lands here
  assign saver_next = all_points_on && !display_on;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_saver      <= 1'b1;
      osc_enable       <= 1'b0;
      supply_enable    <= 1'b0;
      drivers_grounded <= 1'b1;
      pixels_forced_on <= 1'b0;
    end else begin
      power_saver      <= saver_next;
      osc_enable       <= !saver_next;
      supply_enable    <= !saver_next && (power_ctrl != RST_PWR);
      drivers_grounded <= saver_next;
      pixels_forced_on <= all_points_on && !saver_next;
    end
  end

  // ----------------------------------------------------------------
  // Host-facing status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata  <= '0;
      host_rvalid <= 1'b0;
      host_wready <= 1'b0;
    end else begin
      host_rdata  <= rdata_reg;
      host_rvalid <= rvalid_reg;
      host_wready <= fifo_in_ready;
    end
  end

endmodule : lcdc_decoder
`default_nettype wire

// [verification/lcdc_chk.sv]
// Purpose: Port-level assertions for the LCD command decoder.
// Assumes: One clock; the write queue is empty whenever a read is issued.
// Notes:   Bound to every decoder instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module lcdc_chk
  import lcdc_pkg::*;
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_n,
  // Host side
  input wire logic               cmd_data_select,
  input wire logic               write_strobe,
  input wire logic               read_strobe,
  input wire logic [BYTE_W-1:0]  host_wdata,
  input wire logic               serial_select,
  // Settings
  input wire logic [PWR_W-1:0]   power_ctrl,
  input wire logic [RATIO_W-1:0] regulator_divider_ratio,
  input wire logic [VOL_W-1:0]   volume_field,
  input wire logic               bias_sixth,
  input wire logic               display_on,
  input wire logic               all_points_on,
  input wire logic [PAGE_W-1:0]  page_addr,
  input wire logic [COL_W-1:0]   column_addr,
  input wire logic               rmw_active,
  input wire logic               test_mode,
  // Power saver effects
  input wire logic               power_saver,
  input wire logic               osc_enable,
  input wire logic               supply_enable,
  input wire logic               drivers_grounded,
  input wire logic               pixels_forced_on
);
  // ------------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic              cmd_wr;
  logic              saver_want;
  logic [PAGE_W-1:0] pg_want_reg;
  logic [COL_W-1:0]  col_rd_reg;

  assign cmd_wr     = write_strobe && !cmd_data_select && !serial_select;
  assign saver_want = all_points_on && !display_on;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pg_want_reg <= RST_PAGE;
    else if (cmd_wr && host_wdata[7:4] == 4'hb) pg_want_reg <= host_wdata[PAGE_W-1:0];
  end

  // Column seen when a read is taken; reads in RMW must leave it alone
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) col_rd_reg <= RST_COL;
    else if (read_strobe) col_rd_reg <= column_addr;
  end

  sequence s_rmw_read;
    rmw_active && read_strobe && cmd_data_select && !serial_select ##1 rmw_active [*3];
  endsequence
  sequence s_disp_cmd;
    test_mode && cmd_wr && (host_wdata & MASK_BIT0) == CMD_DISP_ONOFF;
  endsequence

  reset_vals_a: assert property ($rose(rst_n) |-> power_ctrl == 3'h0 &&
    regulator_divider_ratio == 3'h0 && volume_field == 5'h10 && bias_sixth)
    else $error("reset values wrong");
  saver_set_a: assert property (power_saver == $past(saver_want))
    else $error("power saver wrong");
  saver_outs_a: assert property (drivers_grounded == power_saver && osc_enable != power_saver)
    else $error("saver outputs wrong");
  supply_off_a: assert property (supply_enable |-> !power_saver && $past(power_ctrl) != 3'h0)
    else $error("supply on wrongly");
  forced_on_a: assert property (pixels_forced_on |-> $past(all_points_on) && !power_saver)
    else $error("pixels forced wrongly");
  rmw_hold_a: assert property (s_rmw_read |-> column_addr == col_rd_reg)
    else $error("column moved on rmw read");
  test_exit_a: assert property (s_disp_cmd |-> ##[2:8] !test_mode)
    else $error("test mode kept");
  page_load_a: assert property (cmd_wr && host_wdata[7:4] == 4'hb |-> ##[2:8] page_addr == pg_want_reg)
    else $error("page not loaded");
endmodule // lcdc_chk

bind lcdc_decoder lcdc_chk i_chk (.*);
`default_nettype wire

// [verification/lcdc_host.sv]
// Purpose: Host processor model driving the decoder's parallel and serial ports.
// Assumes: Decoder answers on sys_clk; one request at a time.
// Notes:   Released data lines carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module lcdc_host
  import lcdc_pkg::*;
(
  // Clock and decoder answers
  input  wire logic              sys_clk,
  input  wire logic              host_wready,
  input  wire logic              host_rvalid,
  input  wire logic [BYTE_W-1:0] host_rdata,
  // Parallel port
  output logic                   cmd_data_select,
  output logic                   write_strobe,
  output logic                   read_strobe,
  output logic      [BYTE_W-1:0] host_wdata,
  // Serial port
  output logic                   serial_select,
  output logic                   serial_clk_en,
  output logic                   serial_bit
);
  initial begin
    cmd_data_select = 1'b0;
    write_strobe    = 1'b0;
    read_strobe     = 1'b0;
    host_wdata      = 8'h00;
    serial_select   = 1'b0;
    serial_clk_en   = 1'b0;
    serial_bit      = 1'b0;
  end

  // Room is awaited first since the ready flag lags the queue by a cycle
  task automatic wr(input logic cd, input logic [BYTE_W-1:0] b);
    for (int n = 0; n < 50 && host_wready !== 1'b1; n++) @(negedge sys_clk);
    @(posedge sys_clk);
    cmd_data_select <= cd;
    write_strobe    <= 1'b1;
    host_wdata      <= b;
    @(posedge sys_clk);
    write_strobe <= 1'b0;
    host_wdata   <= ~b;
  endtask

  task automatic rd(output logic [BYTE_W-1:0] d);
    d = 8'hxx;
    @(posedge sys_clk);
    cmd_data_select <= 1'b1;
    read_strobe     <= 1'b1;
    @(posedge sys_clk);
    read_strobe <= 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(negedge sys_clk);
      if (host_rvalid === 1'b1) begin
        d = host_rdata;
        break;
      end
    end
  endtask

  task automatic ser(input logic cd, input logic [BYTE_W-1:0] b);
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      serial_select   <= 1'b1;
      cmd_data_select <= cd;
      serial_clk_en   <= 1'b1;
      serial_bit      <= b[i];
      @(posedge sys_clk);
      serial_clk_en <= 1'b0;
    end
    serial_select <= 1'b0;
    serial_bit    <= ~b[0];
  endtask
endmodule // lcdc_host
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the LCD command decoder.
// Assumes: Commands settle within four cycles of their write strobe.
// Notes:   Host traffic comes from the host model instance h.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lcdc_pkg::*;
;
  logic sys_clk, rst_n, cmd_data_select, write_strobe, read_strobe, host_rvalid, host_wready;
  logic serial_select, serial_clk_en, serial_bit, bias_sixth, display_on, display_reverse;
  logic all_points_on, segment_reverse, common_reverse, rmw_active, test_mode, power_saver;
  logic osc_enable, supply_enable, drivers_grounded, pixels_forced_on;
  logic [7:0] host_wdata, host_rdata, d;
  logic [2:0] power_ctrl, regulator_divider_ratio;
  logic [4:0] volume_field;
  logic [5:0] start_line;
  logic [3:0] page_addr;
  logic [6:0] column_addr;
  int         err_total;
  int         checked;

  lcdc_decoder i_dut (.*);
  lcdc_host h (.*);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp=%h seen=%h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic settle();
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic cmd(logic [7:0] b);
    h.wr(1'b0, b);
    settle();
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_power();
    chk("rst", {power_ctrl, regulator_divider_ratio, volume_field, bias_sixth}, 12'h021);
    chk("saver", {power_saver, osc_enable, drivers_grounded}, 3'b101);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      chk("pwr", power_ctrl, 16'(i));
      cmd(8'h20 | 8'(i));
      chk("ratio", regulator_divider_ratio, 16'(i));
    end
    chk("supply", supply_enable, 1'b0);
    cmd(8'h9f);
    chk("vol", volume_field, 5'h1f);
    cmd(8'h80);
    chk("vol", volume_field, 5'h00);
    cmd(8'ha2);
    chk("bias", bias_sixth, 1'b0);
    cmd(8'ha3);
    chk("bias", bias_sixth, 1'b1);
    // Back-to-back writes must execute in order
    h.wr(1'b0, 8'h21);
    h.wr(1'b0, 8'h24);
    h.wr(1'b0, 8'h26);
    settle();
    chk("ratio", regulator_divider_ratio, 3'h6);
  endtask

  task automatic t_saver();
    cmd(8'ha4);
    chk("saver", {power_saver, osc_enable, supply_enable}, 3'b011);
    cmd(8'ha5);
    chk("saver", {power_saver, osc_enable, supply_enable, drivers_grounded}, 4'h9);
    cmd(8'h23);
    chk("ratio", regulator_divider_ratio, 3'h3);
    cmd(8'ha7);
    cmd(8'haf);
    chk("allon", {power_saver, pixels_forced_on, display_reverse}, 3'b011);
    cmd(8'ha6);
    chk("rev", display_reverse, 1'b0);
    cmd(8'hae);
    chk("saver", power_saver, 1'b1);
    cmd(8'ha4);
  endtask

  task automatic t_addr();
    cmd(8'hb3);
    cmd(8'h15);
    cmd(8'h03);
    cmd(8'h7f);
    chk("addr", {page_addr, column_addr, start_line}, {4'h3, 7'h53, 6'h3f});
    cmd(8'ha1);
    cmd(8'hc8);
    chk("dir", {segment_reverse, common_reverse}, 2'b11);
    cmd(8'ha0);
    cmd(8'hc7);
    chk("dir", {segment_reverse, common_reverse}, 2'b00);
    cmd(8'he1);
    cmd(8'ha8);
    cmd(8'he3);
    chk("ign", {test_mode, page_addr, column_addr}, {1'b0, 4'h3, 7'h53});
  endtask

  task automatic t_rmw();
    cmd(8'hb2);
    cmd(8'h11);
    cmd(8'h00);
    h.wr(1'b1, 8'h5a);
    h.wr(1'b1, 8'ha5);
    settle();
    chk("col", column_addr, 7'h12);
    cmd(8'h11);
    cmd(8'h00);
    cmd(8'he0);
    h.rd(d);
    h.rd(d);
    chk("rmwrd", {rmw_active, column_addr, d}, {1'b1, 7'h10, 8'h5a});
    h.wr(1'b1, 8'h3c);
    settle();
    chk("col", column_addr, 7'h11);
    cmd(8'hb5); // Page only: column set is barred here
    cmd(8'hee);
    chk("end", {rmw_active, page_addr, column_addr}, {1'b0, 4'h5, 7'h10});
    cmd(8'hb2);
    h.rd(d);
    h.rd(d);
    chk("rd", d, 8'h3c);
  endtask

  task automatic t_test();
    cmd(8'hd5);
    chk("test", test_mode, 1'b1);
    cmd(8'haf);
    chk("test", {test_mode, display_on}, 2'b01);
    cmd(8'hf0);
    cmd(8'he2);
    chk("rcmd", {test_mode, display_on, all_points_on, power_ctrl, volume_field}, 11'h110);
    chk("rcmd", {page_addr, column_addr}, 11'h000);
    cmd(8'hb2);
    cmd(8'h11);
    cmd(8'h00);
    h.rd(d);
    h.rd(d);
    chk("keep", d, 8'h3c);
    cmd(8'hd5);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    chk("pin", test_mode, 1'b0);
  endtask

  task automatic t_serial();
    h.ser(1'b0, 8'h93);
    settle();
    chk("ser", volume_field, 5'h13);
    h.ser(1'b1, 8'h77);
    settle();
    chk("ser", column_addr, 7'h01);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    t_power();
    t_saver();
    t_addr();
    t_rmw();
    t_test();
    t_serial();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
